// ===== conv_trigger.sv
// module: conversion start logic with auto trigger selector, sleep handling and completion flags
//
// Function
// - rc clock in sleep: convert, flag done
// - other clock in sleep: hold trigger until wake
// - selected source rising edge sets go flag
// - five-bit field selects trigger source
// - code 0 disables, code 1 pin
// - timer overflow and period match codes
// - codes 9 and A measurement timers
// - capture, pwm, comparator, pin change, logic cells
// - register reads trigger on codes 1C,1D,1F
// - sampling capacitor never discharged between conversions
// - completion clears go unless continuous, sets done
// - done flag set regardless of mask
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module conv_trigger
  import trig_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire reg_req_s    req,
  output logic [31:0]      rdata,
  input  wire sources_s    src,
  input  wire logic        sleeping,
  input  wire logic [9:0]  conv_result,
  output logic             converting,
  output logic             conv_start,
  output logic             sample_discharge,
  output logic             irq
);

  typedef struct packed {
    logic [31:0] rdata;
    logic        go;
    logic        cont;
    logic        rc_clock;
    logic        pending;
    logic [4:0]  trig_sel;
    logic [4:0]  pin_sel;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [7:0]  error_res;
    logic [9:0]  result;
    logic [5:0]  chan_sel;
    logic [7:0]  conv_time;
    logic [7:0]  count;
    conv_e       state;
    logic        start;
    logic        irq;
  } state_s;

  state_s st_q;
  state_s st_d;

  logic [NUM_SOURCES-1:0] src_vec;
  logic                   sel_level;
  logic                   hw_rise;
  logic                   rd_hit_err;
  logic                   rd_hit_res;
  logic                   rd_hit_chan;
  logic                   read_trig;
  logic                   trig_evt;
  logic                   rc_sleep_ok;
  logic                   start_now;
  logic                   conv_end;
  logic                   sw_go;
  logic                   sw_stop;
  logic [1:0]             set_bits;

  // map every selector code onto one lane of the source vector
  always_comb begin
    src_vec          = '0;
    src_vec[5'h01]   = src.trigger_pin;
    src_vec[5'h02]   = src.timer16_ovf[0];
    src_vec[5'h03]   = src.timer16_ovf[1];
    src_vec[5'h04]   = src.timer8_match[0];
    src_vec[5'h05]   = src.timer16_ovf[2];
    src_vec[5'h06]   = src.timer8_match[1];
    src_vec[5'h07]   = src.timer16_ovf[3];
    src_vec[5'h08]   = src.timer8_match[2];
    src_vec[5'h09]   = src.meas_match[0];
    src_vec[5'h0A]   = src.meas_match[1];
    src_vec[5'h0F:5'h0B] = src.capture;
    src_vec[5'h11:5'h10] = src.pwm;
    src_vec[5'h13:5'h12] = src.comparator;
    src_vec[5'h14]   = src.pin_change;
    src_vec[5'h18:5'h15] = src.logic_cell;
  end

  // disabled code is forced low; reserved and read codes select lanes 0x19 to 0x1F, which are tied low
  assign sel_level = (st_q.trig_sel == SEL_DISABLED) ? 1'b0 : src_vec[st_q.trig_sel];

  trig_edge u_edge (
    .clock (clock),
    .reset (reset),
    .level (sel_level),
    .rise  (hw_rise)
  );

  // read-triggered codes fire on the read strobe itself, already synchronous
  assign rd_hit_err  = req.rd & (req.addr == OFS_ERROR_RES);
  assign rd_hit_res  = req.rd & (req.addr == OFS_RESULT_HI);
  assign rd_hit_chan = req.rd & (req.addr == OFS_CHAN_SEL);
  assign read_trig   = ((st_q.trig_sel == SEL_READ_ERR)  & rd_hit_err)
                     | ((st_q.trig_sel == SEL_READ_RES)  & rd_hit_res)
                     | ((st_q.trig_sel == SEL_READ_CHAN) & rd_hit_chan);
  assign trig_evt    = hw_rise | read_trig;

  // software writes to the control register
  assign sw_go   = req.wr & (req.addr == OFS_CONTROL) & req.wdata[CTL_GO_BIT];
  assign sw_stop = req.wr & (req.addr == OFS_CONTROL) & ~req.wdata[CTL_GO_BIT];

  // a conversion may start in sleep only on the rc clock
  assign rc_sleep_ok = ~sleeping | st_q.rc_clock;
  assign start_now   = (st_q.state == CONV_IDLE) & st_q.go & ~st_q.pending & rc_sleep_ok;
  assign conv_end    = (st_q.state == CONV_RUN) & (st_q.count == 8'h00);

  // event sources for the sticky status bits
  always_comb begin
    set_bits               = '0;
    set_bits[IRQ_DONE_BIT] = conv_end;
    set_bits[IRQ_TRIG_BIT] = trig_evt;
  end

  // next-state logic for registers, trigger and conversion sequencer
  always_comb begin
    st_d       = st_q;
    st_d.start = 1'b0;
    st_d.rdata = '0;

    // register writes
    if (req.wr) begin
      case (req.addr)
        OFS_CONTROL: begin
          st_d.cont     = req.wdata[CTL_CONT_BIT];
          st_d.rc_clock = req.wdata[CTL_RC_BIT];
          // a zero in the go bit cancels go in every state, so a pending or continuous start can be withdrawn
          st_d.go       = sw_go;
        end
        OFS_TRIG_SEL:   st_d.trig_sel  = req.wdata[4:0];
        OFS_PIN_SEL:    st_d.pin_sel   = req.wdata[4:0];
        OFS_IRQ_MASK:   st_d.mask      = req.wdata[1:0];
        OFS_CHAN_SEL:   st_d.chan_sel  = req.wdata[5:0];
        OFS_CONV_TIME:  st_d.conv_time = req.wdata[7:0];
        OFS_IRQ_STATUS: st_d.status    = st_q.status & ~req.wdata[1:0];
        default: begin
        end
      endcase
    end

    // a hardware trigger during sleep off the rc clock is recorded only
    if (trig_evt) begin
      if (sleeping & ~st_q.rc_clock) begin
        st_d.pending = 1'b1;
      end
      st_d.go = 1'b1;
    end
    if (st_q.pending & ~sleeping) begin
      st_d.pending = 1'b0;
    end

    // sequencer; a software clear of go aborts the conversion unless a trigger arrives in the same cycle
    case (st_q.state)
      CONV_IDLE: begin
        if (start_now) begin
          st_d.state = CONV_RUN;
          st_d.count = st_q.conv_time;
          st_d.start = 1'b1;
        end
      end
      CONV_RUN: begin
        if (sw_stop & ~trig_evt) begin
          st_d.go    = 1'b0;
          st_d.state = CONV_IDLE;
        end else if (conv_end) begin
          st_d.result = conv_result;
          st_d.state  = CONV_DONE;
          if (!st_q.cont) begin
            st_d.go = trig_evt;
          end
        end else begin
          st_d.count = st_q.count - 8'h01;
        end
      end
      CONV_DONE: begin
        st_d.state = CONV_IDLE;
      end
      default: begin
        st_d.state = CONV_IDLE;
      end
    endcase

    // hardware set wins over a write-one clear in the same cycle
    st_d.status = st_d.status | set_bits;

    // read data stands in the cycle after the strobe
    if (req.rd) begin
      case (req.addr)
        OFS_CONTROL:    st_d.rdata = {28'h0000000, st_q.pending, st_q.rc_clock, st_q.cont, st_q.go};
        OFS_TRIG_SEL:   st_d.rdata = {27'h0, st_q.trig_sel};
        OFS_PIN_SEL:    st_d.rdata = {27'h0, st_q.pin_sel};
        OFS_IRQ_STATUS: st_d.rdata = {30'h0, st_q.status};
        OFS_IRQ_MASK:   st_d.rdata = {30'h0, st_q.mask};
        OFS_ERROR_RES:  st_d.rdata = {24'h000000, st_q.error_res};
        OFS_RESULT_HI:  st_d.rdata = {30'h0, st_q.result[9:8]};
        OFS_CHAN_SEL:   st_d.rdata = {26'h0, st_q.chan_sel};
        OFS_CONV_TIME:  st_d.rdata = {24'h000000, st_q.conv_time};
        default:        st_d.rdata = '0;
      endcase
    end

    // error result kept as difference of the last two results
    if (conv_end) begin
      st_d.error_res = conv_result[7:0] - st_q.result[7:0];
    end

    st_d.irq = |(st_d.status & st_d.mask);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_q           <= '0;
      st_q.trig_sel  <= TRIG_SEL_RESET;
      st_q.conv_time <= CONV_TIME_RESET;
      st_q.state     <= CONV_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flip-flops; the hold capacitor is never discharged
  always_ff @(posedge clock) begin
    if (reset) begin
      converting       <= 1'b0;
      sample_discharge <= 1'b0;
    end else begin
      converting       <= (st_d.state == CONV_RUN);
      sample_discharge <= 1'b0;
    end
  end

  assign rdata      = st_q.rdata;
  assign conv_start = st_q.start;
  assign irq        = st_q.irq;

endmodule : conv_trigger

// ===== conv_trigger_monitor.sv
// checker: port level assertions for the conversion trigger block
`timescale 1ns/1ps
module conv_trigger_monitor
  import trig_pkg::*;
(
  input wire logic     clock,
  input wire logic     reset,
  input wire reg_req_s req,
  input wire logic     sleeping,
  input wire logic     converting,
  input wire logic     conv_start,
  input wire logic     sample_discharge,
  input wire logic     irq
);
  logic [4:0] sel_q;
  logic       rc_q;
  logic [1:0] mask_q;
  logic [7:0] time_q;
  logic [8:0] run_q;
  logic       rd_trig;
  logic       abort_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // shadows of the register writes that the properties depend on
  always_ff @(posedge clock) begin
    if (reset) begin
      sel_q  <= TRIG_SEL_RESET;
      rc_q   <= 1'b0;
      mask_q <= 2'h0;
      time_q <= CONV_TIME_RESET;
    end else if (req.wr) begin
      if (req.addr == OFS_TRIG_SEL) sel_q <= req.wdata[4:0];
      if (req.addr == OFS_CONTROL) rc_q <= req.wdata[CTL_RC_BIT];
      if (req.addr == OFS_IRQ_MASK) mask_q <= req.wdata[1:0];
      if (req.addr == OFS_CONV_TIME) time_q <= req.wdata[7:0];
    end
  end
  // run length in a counter, since runs outgrow a short repetition; a software abort ends a run early
  always_ff @(posedge clock) begin
    run_q   <= (converting && !reset) ? run_q + 9'h001 : 9'h000;
    abort_q <= req.wr && (req.addr == OFS_CONTROL) && !req.wdata[CTL_GO_BIT];
  end
  // reads that the selected code turns into a trigger
  assign rd_trig = req.rd && !converting && !sleeping && (
    (sel_q == SEL_READ_ERR && req.addr == OFS_ERROR_RES) ||
    (sel_q == SEL_READ_RES && req.addr == OFS_RESULT_HI) ||
    (sel_q == SEL_READ_CHAN && req.addr == OFS_CHAN_SEL));
  // start, run and completion relations
  a_no_discharge: assert property (!sample_discharge)
    else $error("sample discharge raised");
  a_start_pulse: assert property (conv_start |-> converting ##1 !conv_start)
    else $error("start pulse malformed");
  a_rise_started: assert property ($rose(converting) |-> conv_start)
    else $error("run without start pulse");
  a_read_trigger: assert property (rd_trig |-> ##[1:4] conv_start)
    else $error("register read did not trigger");
  a_sleep_hold: assert property (sleeping && $past(sleeping) && !rc_q |-> !conv_start)
    else $error("conversion began in sleep");
  a_done_irq: assert property ($fell(converting) && !abort_q && mask_q[IRQ_DONE_BIT] |-> ##[0:3] irq)
    else $error("no interrupt after conversion");
  a_irq_masked: assert property (mask_q == 2'h0 && $past(mask_q) == 2'h0 |-> !irq)
    else $error("interrupt while masked");
  a_run_length: assert property ($fell(converting) && !abort_q |-> run_q == {1'b0, time_q} + 9'h001)
    else $error("conversion length wrong");
endmodule : conv_trigger_monitor

bind conv_trigger conv_trigger_monitor u_monitor (.clock(clock), .reset(reset), .req(req), .sleeping(sleeping),
  .converting(converting), .conv_start(conv_start), .sample_discharge(sample_discharge), .irq(irq));

// ===== tb.sv
// testbench: trigger selection, read triggers, sleep handling and completion flags
`timescale 1ns/1ps
module tb;
  import trig_pkg::*;
  logic        clock, reset, sleeping, fire, converting, conv_start, sample_discharge, irq;
  reg_req_s    req;
  logic [31:0] rdata, d;
  sources_s    src;
  logic [9:0]  conv_result;
  logic [4:0]  code;
  logic [23:0] noise;
  integer      seed = 38, failures = 0, tests_run = 0, starts = 0, cycles = 0, s;

  conv_trigger dut (.clock(clock), .reset(reset), .req(req), .rdata(rdata), .src(src), .sleeping(sleeping),
    .conv_result(conv_result), .converting(converting), .conv_start(conv_start),
    .sample_discharge(sample_discharge), .irq(irq));
  trig_source_model far (.clock(clock), .code(code), .fire(fire), .noise(noise), .src(src));

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    req <= '{a, v, 1'b1, 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic pulse();
    fire <= 1'b1;
    idle(6);
    fire <= 1'b0;
  endtask : pulse
  // codes that must start exactly one conversion: every wired source and the three register reads
  function automatic logic starts_on(input logic [4:0] c);
    return (c >= 5'h01 && c <= 5'h18) || c == SEL_READ_ERR || c == SEL_READ_RES || c == SEL_READ_CHAN;
  endfunction : starts_on
  // sources go quiet before the selector moves, else the switch itself reads as an edge
  task automatic try_code(input logic [4:0] c, input logic m);
    logic       exp;
    logic [5:0] ch;
    exp = starts_on(c);
    ch = 6'($random(seed));
    @(posedge clock);
    code <= c;
    noise <= 24'h000000;
    idle(4);
    wr(OFS_IRQ_MASK, {31'h0, m});
    wr(OFS_TRIG_SEL, {27'h0, c});
    rd(OFS_TRIG_SEL);
    check(d, {27'h0, c});
    s = starts;
    @(posedge clock);
    noise <= 24'($random(seed));
    conv_result <= 10'($random(seed));
    wr(OFS_CHAN_SEL, {26'h0, ch});
    // acquisition time is left to software before any trigger
    idle(6);
    pulse();
    if (c == SEL_READ_ERR) rd(OFS_ERROR_RES);
    if (c == SEL_READ_RES) rd(OFS_RESULT_HI);
    if (c == SEL_READ_CHAN) begin
      rd(OFS_CHAN_SEL);
      check(d, {26'h0, ch});
    end
    idle(10);
    check(starts - s, exp);
    rd(OFS_IRQ_STATUS);
    check(d[IRQ_DONE_BIT], exp);
    check(irq, exp & m);
    rd(OFS_CONTROL);
    check(d[CTL_GO_BIT], 1'b0);
    check(converting, 1'b0);
    wr(OFS_IRQ_STATUS, 32'h3);
  endtask : try_code

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // start pulses counted, and a ceiling of 20000 cycles on the whole simulation
  always @(posedge clock) begin
    cycles++;
    if (conv_start === 1'b1) starts++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end

  // main sequence: reset values, every code then random codes, then both sleep cases
  initial begin
    reset = 1'b1;
    sleeping = 1'b0;
    fire = 1'b0;
    code = 5'h00;
    noise = 24'h000000;
    conv_result = 10'h000;
    req = '0;
    idle(10);
    reset <= 1'b0;
    rd(OFS_TRIG_SEL);
    check(d, {27'h0, TRIG_SEL_RESET});
    rd(8'h24);
    check(d, 32'h0);
    wr(OFS_CONV_TIME, 32'h2);
    for (int i = 0; i < 52; i++) try_code(i < 32 ? 5'(i) : 5'($unsigned($random(seed)) % 24 + 1), i[0]);
    @(posedge clock);
    code <= SEL_PIN;
    noise <= 24'h000000;
    for (int rc = 0; rc < 2; rc++) begin
      wr(OFS_TRIG_SEL, {27'h0, SEL_PIN});
      wr(OFS_CONTROL, 32'(rc) << CTL_RC_BIT);
      s = starts;
      sleeping <= 1'b1;
      pulse();
      idle(10);
      check(starts - s, rc);
      rd(OFS_IRQ_STATUS);
      check(d[IRQ_DONE_BIT], rc);
      rd(OFS_CONTROL);
      check(d[CTL_PEND_BIT], !rc);
      @(posedge clock);
      sleeping <= 1'b0;
      idle(12);
      check(starts - s, 1);
      wr(OFS_IRQ_STATUS, 32'h3);
    end
    // continuous operation keeps go set and restarts until software writes go low
    wr(OFS_CONTROL, (32'h1 << CTL_CONT_BIT) | (32'h1 << CTL_GO_BIT));
    s = starts;
    idle(20);
    check(starts - s > 2, 1'b1);
    rd(OFS_CONTROL);
    check(d[CTL_GO_BIT], 1'b1);
    wr(OFS_CONTROL, 32'h0);
    idle(10);
    s = starts;
    idle(10);
    check(starts - s, 0);
    check(converting, 1'b0);
    // every conversion since the last random pick captured the same sample
    rd(OFS_RESULT_HI);
    check(d, {30'h0, conv_result[9:8]});
    check(sample_discharge, 1'b0);
    test_done();
  end
endmodule : tb

// ===== trig_edge.sv
// module: two-stage synchroniser with rising edge detect for the selected trigger source
`timescale 1ns/1ps
module trig_edge
  import trig_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic level,
  output logic      rise
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } edge_s;

  edge_s st_q;
  edge_s st_d;

  // only sync and last feed the compare; meta is read by sync alone
  always_comb begin
    st_d      = st_q;
    st_d.meta = level;
    st_d.sync = st_q.meta;
    st_d.last = st_q.sync;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // one pulse per rising edge of the synchronised level
  assign rise = st_q.sync & ~st_q.last;

endmodule : trig_edge

// ===== trig_pkg.sv
// package: register map, trigger codes, field layouts and state types for the conversion trigger block
package trig_pkg;

  // register offsets (byte addresses on the plain register port)
  localparam logic [7:0] OFS_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_TRIG_SEL   = 8'h04;
  localparam logic [7:0] OFS_PIN_SEL    = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h10;
  localparam logic [7:0] OFS_ERROR_RES  = 8'h14;
  localparam logic [7:0] OFS_RESULT_HI  = 8'h18;
  localparam logic [7:0] OFS_CHAN_SEL   = 8'h1C;
  localparam logic [7:0] OFS_CONV_TIME  = 8'h20;

  // control register bit positions
  localparam int CTL_GO_BIT   = 0;
  localparam int CTL_CONT_BIT = 1;
  localparam int CTL_RC_BIT   = 2;
  localparam int CTL_PEND_BIT = 3;

  // status and mask bit positions
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_TRIG_BIT = 1;

  // reset values
  localparam logic [4:0] TRIG_SEL_RESET  = 5'h00;
  localparam logic [7:0] CONV_TIME_RESET = 8'h0B;

  // trigger selector codes
  localparam logic [4:0] SEL_DISABLED  = 5'h00;
  localparam logic [4:0] SEL_PIN       = 5'h01;
  localparam logic [4:0] SEL_RSV_LO    = 5'h19;
  localparam logic [4:0] SEL_RSV_HI    = 5'h1B;
  localparam logic [4:0] SEL_READ_ERR  = 5'h1C;
  localparam logic [4:0] SEL_READ_RES  = 5'h1D;
  localparam logic [4:0] SEL_RSV_ONE   = 5'h1E;
  localparam logic [4:0] SEL_READ_CHAN = 5'h1F;

  // width of the source vector, one lane per selector code; hardware sources are wired at codes 0x01 to 0x18
  localparam int NUM_SOURCES = 32;

  // hardware event sources, one field per source group
  typedef struct packed {
    logic [3:0] logic_cell;    // codes 0x15..0x18
    logic       pin_change;    // code 0x14
    logic [1:0] comparator;    // codes 0x12..0x13
    logic [1:0] pwm;           // codes 0x10..0x11
    logic [4:0] capture;       // codes 0x0B..0x0F
    logic [1:0] meas_match;    // codes 0x09..0x0A
    logic [3:0] timer16_ovf;   // codes 0x02,0x03,0x05,0x07
    logic [2:0] timer8_match;  // codes 0x04,0x06,0x08
    logic       trigger_pin;
  } sources_s;

  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  // conversion sequencer states, gray along idle -> convert -> done
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_RUN  = 2'b01,
    CONV_DONE = 2'b11
  } conv_e;

endpackage : trig_pkg

// ===== trig_source_model.sv
// partner: on-chip event sources feeding the trigger selector
`timescale 1ns/1ps
module trig_source_model
  import trig_pkg::*;
(
  input  wire logic        clock,
  input  wire logic [4:0]  code,
  input  wire logic        fire,
  input  wire logic [23:0] noise,
  output sources_s         src
);
  // source bit behind codes 0x00..0x08; codes 0x09..0x18 sit at code minus one
  localparam int LOW_IDX [0:8] = '{0, 0, 4, 5, 1, 6, 2, 7, 3};
  logic [23:0] sel_bit;
  always_comb begin
    sel_bit = 24'h000000;
    if (code >= 5'h01 && code <= 5'h18) begin
      sel_bit[code <= 5'h08 ? LOW_IDX[code] : int'(code) - 1] = 1'b1;
    end
  end
  // other sources toggle freely; the chosen one rises only on command
  always_ff @(posedge clock) begin
    src <= sources_s'(fire ? sel_bit : noise & ~sel_bit);
  end
endmodule : trig_source_model
